// [pfg_defs.vh]
// register offsets, field positions and timing counts for the fault guard block
`ifndef PFG_DEFS_VH
`define PFG_DEFS_VH
`define PFG_OFF_CNT        12'h000
`define PFG_OFF_CMPA       12'h004
`define PFG_OFF_CMPB       12'h008
`define PFG_OFF_CMPC       12'h00C
`define PFG_OFF_CMPD       12'h010
`define PFG_OFF_HIGH       12'h014
`define PFG_OFF_CTLD       12'h018
`define PFG_OFF_MODE       12'h01C
`define PFG_OFF_FLAG       12'h020
`define PFG_OFF_PORT_B_LATCH      12'h024
`define PFG_CTLD_GUARD     0
`define PFG_CTLD_IRQEN     1
`define PFG_CTLD_SRC       2
`define PFG_CTLD_EDGE      3
`define PFG_CTLD_FILT      4
`define PFG_CTLD_RST       8'h00
`define PFG_FILT_SAMPLES   4
`define PFG_MODE_W         8
`define PFG_OUT_W          6
`endif

// [pfg_filter.v]
// four-sample noise filter stage for the fault trigger path
`timescale 1ns/1ps
`default_nettype none
`include "pfg_defs.vh"
module pfg_filter (
   // clock and reset
   input  wire  mclk,
   input  wire  sys_rst,
   // sample in, filtered level out
   input  wire  din,
   output reg   dout_r
);
   reg [`PFG_FILT_SAMPLES-1:0] hist_r;
   always @(posedge mclk) begin
      if (sys_rst) begin
         hist_r <= {`PFG_FILT_SAMPLES{1'b0}};
         dout_r <= 1'b0;
      end else begin
         hist_r <= {hist_r[`PFG_FILT_SAMPLES-2:0], din};
         // output changes only when all samples agree
         if (&{hist_r[`PFG_FILT_SAMPLES-2:0], din}) begin // RQ10 RQ11
            dout_r <= 1'b1;
         end else if (~|{hist_r[`PFG_FILT_SAMPLES-2:0], din}) begin // RQ10 RQ11
            dout_r <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// [pfg_guard.v]
// fault guard and 10-bit wide register access, APB slave
//
// Overview of operation
// RQ1: armed guard plus selected-direction edge on trigger enters fault protection.
// RQ2: fault clears output mode bits, pins then show port B latch.
// RQ3: guard enable bit clears in the same cycle as mode bits.
// RQ4: fault with interrupt enable set raises the fault interrupt request.
// RQ5: software polls the self-clearing guard enable bit to see faults.
// RQ6: trigger source is event pin by default, comparator when select bit set.
// RQ7: changing the source may itself be detected as an edge.
// RQ8: software should clear fault flag after changing source, edge or enable.
// RQ9: both trigger inputs synchronised by two flops, one shared edge detector.
// RQ10: filter passes new level only after four equal samples.
// RQ11: filter enable bit in control register d adds four cycles delay.
// RQ12: filter samples on the system clock, no prescaler involved.
// RQ13: driving the event pin's port output can trigger a fault.
// RQ14: counter and compare a-d are 10 bits, reached by byte accesses.
// RQ15: one shared 2-bit holding register serves all 10-bit registers.
// RQ16: low byte write loads held high bits and low byte together.
// RQ17: low byte read copies upper two bits into holding register.
// RQ18: master writes holding register first, then low byte.
// RQ19: master reads low byte first, then holding register.
// RQ20: main code disables interrupts around each two-byte access.
// RQ21: holding register may be written once for several low-byte writes.
// RQ22: fault sets a sticky flag that software clears by writing one.
`timescale 1ns/1ps
`default_nettype none
`include "pfg_defs.vh"
module pfg_guard (
   // clock and reset
   input  wire         mclk,
   input  wire         sys_rst,
   // apb slave
   input  wire         psel,
   input  wire         penable,
   input  wire         pwrite,
   input  wire [11:0]  paddr,
   input  wire [31:0]  pwdata,
   output reg  [31:0]  prdata,
   output reg          pready,
   output reg          pslverr,
   // trigger inputs from outside the clock domain
   input  wire         ext_event_pin,
   input  wire         comparator_out,
   // waveform from the compare units
   input  wire [5:0]   pwm_wave,
   // pin drive and status
   output reg  [5:0]   pwm_pin_r,
   output reg  [7:0]   compare_output_mode_bits_r,
   output reg          fault_irq_r,
   output reg  [9:0]   counter_value_r,
   output reg  [9:0]   compare_a_r,
   output reg  [9:0]   compare_b_r,
   output reg  [9:0]   compare_c_r,
   output reg  [9:0]   compare_d_r
);
   reg  [1:0]  shared_high_byte_r;
   reg  [7:0]  control_reg_d_r;
   reg         fault_flag_r;
   reg  [5:0]  port_b_latch_r;
   reg  [1:0]  ev_sync_r;
   reg  [1:0]  ac_sync_r;
   reg         sel_level_r;
   reg         prev_r;
   reg  [9:0]  wide_rd;
   reg  [31:0] rdata_nxt;
   reg         hit;
   wire        filt_level;
   wire        src_level;
   wire        det_level;
   wire        edge_hit;
   wire        fault;
   wire        wr_en;
   wire        rd_en;
   wire        low_wr;
   wire        low_rd;
   wire [9:0]  wide_wval;

   // two-flop synchronisers for both trigger inputs
   always @(posedge mclk) begin
      if (sys_rst) begin
         ev_sync_r <= 2'h0;
         ac_sync_r <= 2'h0;
      end else begin
         ev_sync_r <= {ev_sync_r[0], ext_event_pin}; // RQ9 RQ13
         ac_sync_r <= {ac_sync_r[0], comparator_out}; // RQ9
      end
   end

   // source mux after the second flop; switching may look like an edge
   assign src_level = control_reg_d_r[`PFG_CTLD_SRC] ? ac_sync_r[1] : ev_sync_r[1]; // RQ6 RQ7

   always @(posedge mclk) begin
      if (sys_rst) begin
         sel_level_r <= 1'b0;
      end else begin
         sel_level_r <= src_level;
      end
   end

   pfg_filter u_filt (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .din     (sel_level_r),
      .dout_r  (filt_level)
   );

   // filter runs on mclk every cycle, no prescaler enable
   assign det_level = control_reg_d_r[`PFG_CTLD_FILT] ? filt_level : sel_level_r; // RQ11 RQ12

   always @(posedge mclk) begin
      if (sys_rst) begin
         prev_r <= 1'b0;
      end else begin
         prev_r <= det_level;
      end
   end

   // edge bit set selects rising, clear selects falling
   assign edge_hit = control_reg_d_r[`PFG_CTLD_EDGE] ? (det_level & ~prev_r) : (~det_level & prev_r); // RQ9
   assign fault    = control_reg_d_r[`PFG_CTLD_GUARD] & edge_hit; // RQ1

   // apb decode
   assign wr_en     = psel & penable & pwrite;
   assign rd_en     = psel & penable & ~pwrite;
   assign low_wr    = wr_en & hit & (paddr <= `PFG_OFF_CMPD);
   assign low_rd    = rd_en & hit & (paddr <= `PFG_OFF_CMPD);
   assign wide_wval = {shared_high_byte_r, pwdata[7:0]};

   always @* begin
      hit       = 1'b1;
      wide_rd   = 10'h000;
      rdata_nxt = 32'h00000000;
      case (paddr)
         `PFG_OFF_CNT:   wide_rd = counter_value_r;
         `PFG_OFF_CMPA:  wide_rd = compare_a_r;
         `PFG_OFF_CMPB:  wide_rd = compare_b_r;
         `PFG_OFF_CMPC:  wide_rd = compare_c_r;
         `PFG_OFF_CMPD:  wide_rd = compare_d_r;
         `PFG_OFF_HIGH:  rdata_nxt = {30'h00000000, shared_high_byte_r};
         `PFG_OFF_CTLD:  rdata_nxt = {24'h000000, control_reg_d_r}; // RQ5
         `PFG_OFF_MODE:  rdata_nxt = {24'h000000, compare_output_mode_bits_r};
         `PFG_OFF_FLAG:  rdata_nxt = {31'h00000000, fault_flag_r};
         `PFG_OFF_PORT_B_LATCH: rdata_nxt = {26'h0000000, port_b_latch_r};
         default:        hit = 1'b0;
      endcase
      if (hit & (paddr <= `PFG_OFF_CMPD)) begin
         rdata_nxt = {24'h000000, wide_rd[7:0]}; // RQ14
      end
   end

   // apb answer: one access cycle, error on unmapped address
   always @(posedge mclk) begin
      if (sys_rst) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit;
         if (psel & ~penable & ~pwrite) begin
            prdata <= rdata_nxt;
         end
      end
   end

   // wide registers and the shared high byte
   always @(posedge mclk) begin
      if (sys_rst) begin
         shared_high_byte_r <= 2'h0;
         counter_value_r    <= 10'h000;
         compare_a_r        <= 10'h000;
         compare_b_r        <= 10'h000;
         compare_c_r        <= 10'h000;
         compare_d_r        <= 10'h000;
      end else begin
         if (pready & wr_en & (paddr == `PFG_OFF_HIGH)) begin
            shared_high_byte_r <= pwdata[1:0]; // RQ15
         end else if (pready & low_rd) begin
            shared_high_byte_r <= wide_rd[9:8]; // RQ17
         end
         if (pready & low_wr) begin
            case (paddr)
               `PFG_OFF_CNT:  counter_value_r <= wide_wval; // RQ16
               `PFG_OFF_CMPA: compare_a_r     <= wide_wval; // RQ16
               `PFG_OFF_CMPB: compare_b_r     <= wide_wval; // RQ16
               `PFG_OFF_CMPC: compare_c_r     <= wide_wval; // RQ16
               default:       compare_d_r     <= wide_wval; // RQ16
            endcase
         end
      end
   end

   // control, mode bits, flag and interrupt
   always @(posedge mclk) begin
      if (sys_rst) begin
         control_reg_d_r            <= `PFG_CTLD_RST;
         compare_output_mode_bits_r <= 8'h00;
         fault_flag_r               <= 1'b0;
         port_b_latch_r             <= 6'h00;
         fault_irq_r                <= 1'b0;
      end else begin
         if (pready & wr_en & (paddr == `PFG_OFF_CTLD)) begin
            control_reg_d_r <= pwdata[7:0];
         end
         if (pready & wr_en & (paddr == `PFG_OFF_MODE)) begin
            compare_output_mode_bits_r <= pwdata[7:0];
         end
         if (pready & wr_en & (paddr == `PFG_OFF_PORT_B_LATCH)) begin
            port_b_latch_r <= pwdata[5:0];
         end
         if (pready & wr_en & (paddr == `PFG_OFF_FLAG) & pwdata[0]) begin
            fault_flag_r <= 1'b0; // RQ8
         end
         if (fault) begin
            compare_output_mode_bits_r            <= 8'h00; // RQ2
            control_reg_d_r[`PFG_CTLD_GUARD]      <= 1'b0; // RQ3
            fault_flag_r                          <= 1'b1; // RQ22
         end
         fault_irq_r <= (fault_flag_r | fault) & control_reg_d_r[`PFG_CTLD_IRQEN]; // RQ4
      end
   end

   // pins: waveform when either mode bit for the pair is set, else port latch
   genvar gi;
   generate
      for (gi = 0; gi < `PFG_OUT_W; gi = gi + 1) begin : g_pin
         always @(posedge mclk) begin
            if (sys_rst) begin
               pwm_pin_r[gi] <= 1'b0;
            end else if (|compare_output_mode_bits_r[2*(gi/2)+1:2*(gi/2)]) begin
               pwm_pin_r[gi] <= pwm_wave[gi];
            end else begin
               pwm_pin_r[gi] <= port_b_latch_r[gi]; // RQ2
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// [pfg_monitor.sv]
// port assertions for the fault guard block
`timescale 1ns/1ps
`default_nettype none
module pfg_monitor (
   // clock and reset
   input wire logic        mclk,
   input wire logic        sys_rst,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // status
   input wire logic [7:0]  compare_output_mode_bits_r,
   input wire logic [9:0]  counter_value_r
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   wire acc = psel && penable && pready;
   wire map = paddr <= 12'h024 && paddr[1:0] == 2'h0;
   wire cnt_wr = acc && pwrite && paddr == 12'h000;
   sequence s_setup; psel && !penable; endsequence
   sequence s_answer; pready ##1 !pready; endsequence
   property p_no_wait; s_setup |=> s_answer; endproperty
   a_no_wait: assert property (p_no_wait) else $error("late pready");
   property p_idle; !psel |=> !pready; endproperty
   a_idle: assert property (p_idle) else $error("pready while idle");
   property p_unmap; acc && !map |-> pslverr && (pwrite || prdata == 32'h0); endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped not refused");
   property p_err; pslverr |-> pready && !map; endproperty
   a_err: assert property (p_err) else $error("stray pslverr");
   property p_lo_wr; cnt_wr |=> counter_value_r[7:0] == $past(pwdata[7:0]); endproperty
   a_lo_wr: assert property (p_lo_wr) else $error("low byte lost");
   property p_hold; $changed(counter_value_r) |-> $past(cnt_wr); endproperty
   a_hold: assert property (p_hold) else $error("counter moved");
   property p_lo_rd; acc && !pwrite && paddr == 12'h000 |-> prdata[7:0] == counter_value_r[7:0]; endproperty
   a_lo_rd: assert property (p_lo_rd) else $error("bad low read");
   property p_mode;
      $changed(compare_output_mode_bits_r) |-> compare_output_mode_bits_r == 8'h00 || $past(acc && pwrite);
   endproperty
   a_mode: assert property (p_mode) else $error("mode bits moved");
endmodule
bind pfg_guard pfg_monitor pfg_monitor_inst (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .compare_output_mode_bits_r(compare_output_mode_bits_r), .counter_value_r(counter_value_r));
`default_nettype wire

// [pfg_cpu_model.sv]
// cpu side apb master model
`timescale 1ns/1ps
`default_nettype none
module pfg_cpu_model (
   // clock
   input  wire logic        mclk,
   // apb master
   output var  logic        psel = 1'b0,
   output var  logic        penable = 1'b0,
   output var  logic        pwrite = 1'b0,
   output var  logic [11:0] paddr = 12'h000,
   output var  logic [31:0] pwdata = 32'h0,
   input  wire logic [31:0] prdata,
   input  wire logic        pready
);
   // one master only, so no two-byte access is ever split
   task xfer(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] q);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~pwdata;
      @(posedge mclk);
   endtask
endmodule
`default_nettype wire

// [test_pfg_guard.sv]
// self-checking bench for the fault guard block
`timescale 1ns/1ps
`default_nettype none
`include "pfg_defs.vh"
module test_pfg_guard;
   logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, ev, cmp, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [5:0] pins;
   logic [7:0] mode;
   logic [9:0] wide [5];
   int bad_count = 0;
   int comparisons = 0;
   logic [11:0] ra [5] = '{`PFG_OFF_CNT, `PFG_OFF_CMPA, `PFG_OFF_CMPB, `PFG_OFF_CMPC, `PFG_OFF_CMPD};
   logic [9:0] rv [5] = '{10'h3FF, 10'h1FF, 10'h2A5, 10'h15A, 10'h301};
   pfg_cpu_model pfg_cpu_model_inst (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));
   pfg_guard pfg_guard_inst (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_event_pin(ev), .comparator_out(cmp), .pwm_wave(6'h15), .pwm_pin_r(pins),
      .compare_output_mode_bits_r(mode), .fault_irq_r(irq), .counter_value_r(wide[0]),
      .compare_a_r(wide[1]), .compare_b_r(wide[2]), .compare_c_r(wide[3]), .compare_d_r(wide[4]));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   task chk(input logic [31:0] s, input logic [31:0] x);
      comparisons++;
      if (s !== x) begin
         bad_count++;
         $display("ERROR %0t seen %h expected %h", $time, s, x);
      end
   endtask
   task wr(input logic [11:0] a, input logic [7:0] d);
      pfg_cpu_model_inst.xfer(1'b1, a, d, q);
   endtask
   task rd(input logic [11:0] a);
      pfg_cpu_model_inst.xfer(1'b0, a, 8'h00, q);
   endtask
   task results;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge mclk);
      bad_count++;
      results;
   end
   initial begin
      sys_rst = 1'b1;
      ev = 1'b0;
      cmp = 1'b1;
      repeat (20) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      chk({22'h0, mode, irq, wide[1]}, 32'h0);
      for (int i = 0; i < 5; i++) begin
         wr(`PFG_OFF_HIGH, {6'h00, rv[i][9:8]});
         wr(ra[i], rv[i][7:0]);
         chk(32'(wide[i]), 32'(rv[i]));
         wr(`PFG_OFF_HIGH, 8'h00);
         rd(ra[i]);
         chk(q, 32'(rv[i][7:0]));
         rd(`PFG_OFF_HIGH);
         chk(q, 32'(rv[i][9:8]));
      end
      wr(`PFG_OFF_HIGH, 8'h02);
      wr(`PFG_OFF_CMPB, 8'h11);
      wr(`PFG_OFF_CMPC, 8'h22);
      chk({wide[2], wide[3]}, {10'h211, 10'h222});
      $display("wide access done");
      wr(`PFG_OFF_PORT_B_LATCH, 8'h2A);
      wr(`PFG_OFF_MODE, 8'h3F);
      wr(`PFG_OFF_CTLD, 8'h0B);
      wr(`PFG_OFF_FLAG, 8'h01);
      chk(32'(pins), 32'h15);
      ev <= 1'b1;
      repeat (12) @(posedge mclk);
      chk({mode, pins, irq}, {8'h00, 6'h2A, 1'b1});
      rd(`PFG_OFF_CTLD);
      chk(q & 32'h1, 32'h0);
      rd(`PFG_OFF_FLAG);
      chk(q & 32'h1, 32'h1);
      wr(`PFG_OFF_FLAG, 8'h01);
      @(posedge mclk);
      chk(32'(irq), 32'h0);
      $display("pin fault done");
      wr(`PFG_OFF_MODE, 8'h3F);
      wr(`PFG_OFF_CTLD, 8'h15);
      wr(`PFG_OFF_FLAG, 8'h01);
      cmp <= 1'b0;
      ev <= 1'b0;
      repeat (2) @(posedge mclk);
      cmp <= 1'b1;
      repeat (12) @(posedge mclk);
      chk(32'(mode), 32'h3F);
      cmp <= 1'b0;
      repeat (6) @(posedge mclk);
      chk(32'(mode), 32'h3F);
      repeat (8) @(posedge mclk);
      chk(32'(mode), 32'h0);
      $display("filtered fault done");
      rd(12'h030);
      chk(q, 32'h0);
      $display("unmapped read done");
      results;
   end
endmodule
`default_nettype wire
